// ---- logic/arq_adc_ctrl.v ----
// Converter control: register slave, start logic, acquisition and
// conversion sequencing, result queue feed.
// Assumes: AXI4-Lite master on aclk; analog core supplies the running
// successive-approximation value on adc_result.
//
// The register offsets and the AXI4-Lite slave port were left to the implementer.
`timescale 1ns/100ps
`default_nettype none
`include "arq_consts.vh"

module arq_adc_ctrl #(
  parameter CLKS_PER_TAD = 16
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire [4:0]   s_axil_awaddr,
  input  wire         s_axil_awvalid,
  output wire         s_axil_awready,
  input  wire [31:0]  s_axil_wdata,
  input  wire [3:0]   s_axil_wstrb,
  input  wire         s_axil_wvalid,
  output wire         s_axil_wready,
  output reg  [1:0]   s_axil_bresp,
  output reg          s_axil_bvalid,
  input  wire         s_axil_bready,
  input  wire [4:0]   s_axil_araddr,
  input  wire         s_axil_arvalid,
  output wire         s_axil_arready,
  output reg  [31:0]  s_axil_rdata,
  output reg  [1:0]   s_axil_rresp,
  output reg          s_axil_rvalid,
  input  wire         s_axil_rready,
  input  wire [4:0]   trig_in,
  input  wire [9:0]   adc_result,
  output reg          hold_connect,
  output reg          conv_run
);

  // ----------------------------------------------------------------------
  // states
  // ----------------------------------------------------------------------
  localparam [3:0] S_IDLE = 4'b0001;
  localparam [3:0] S_ACQ  = 4'b0010;
  localparam [3:0] S_CONV = 4'b0100;
  localparam [3:0] S_WAIT = 4'b1000;

  // ----------------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------------
  reg        on_q;
  reg        go_q;
  reg        cont_q;
  reg        qen_q;
  reg        ljust_q;
  reg [3:0]  acq_q;
  reg [1:0]  rate_q;
  reg [4:0]  tsel_q;
  reg        irqf_q;
  reg [3:0]  state_q;
  reg [3:0]  state_d;
  reg [3:0]  tcnt_q;

  // bus slave state
  reg        aw_hold_q;
  reg        w_hold_q;
  reg [4:0]  awaddr_q;
  reg [31:0] wdata_q;
  reg        wstrb0_q;

  wire       do_wr;
  wire       ar_hs;
  wire       wr_en;
  wire       w_ctl0;
  wire       w_ctl1;
  wire       w_ctl2;
  wire       w_ctl3;
  wire       w_stat;
  wire       wr_map;
  wire       rd_map;
  wire       rd_adv;
  wire       tick;
  wire       trig_hit;
  wire       go_set;
  wire       go_clr_sw;
  wire       seq_start;
  wire       conv_end;
  wire       abort;
  wire       q_wr;
  wire       rate_hit;
  wire       irq_set;
  wire [9:0] q_data;
  wire [1:0] rptr;
  wire       q_empty;
  wire       q_ovr;
  wire [15:0] res16;

  // ----------------------------------------------------------------------
  // write channel: address and data taken in either order
  // ----------------------------------------------------------------------
  assign s_axil_awready = ~aw_hold_q & ~s_axil_bvalid;
  assign s_axil_wready  = ~w_hold_q & ~s_axil_bvalid;
  assign do_wr          = aw_hold_q & w_hold_q & ~s_axil_bvalid;
  assign wr_en          = do_wr & wstrb0_q;
  assign w_ctl0         = wr_en & (awaddr_q == `ARQ_OFF_CTL0);
  assign w_ctl1         = wr_en & (awaddr_q == `ARQ_OFF_CTL1);
  assign w_ctl2         = wr_en & (awaddr_q == `ARQ_OFF_CTL2);
  assign w_ctl3         = wr_en & (awaddr_q == `ARQ_OFF_CTL3);
  assign w_stat         = wr_en & (awaddr_q == `ARQ_OFF_STAT);
  assign wr_map = (awaddr_q == `ARQ_OFF_CTL0) | (awaddr_q == `ARQ_OFF_CTL1) |
                  (awaddr_q == `ARQ_OFF_CTL2) | (awaddr_q == `ARQ_OFF_CTL3) |
                  (awaddr_q == `ARQ_OFF_RES_LO) | (awaddr_q == `ARQ_OFF_RES_HI) |
                  (awaddr_q == `ARQ_OFF_STAT);

  always @(posedge aclk) begin
    if (!aresetn) begin
      aw_hold_q     <= 1'b0;
      w_hold_q      <= 1'b0;
      awaddr_q      <= 5'h00;
      wdata_q       <= 32'h00000000;
      wstrb0_q      <= 1'b0;
      s_axil_bvalid <= 1'b0;
      s_axil_bresp  <= `ARQ_RESP_OKAY;
    end else begin
      if (s_axil_awvalid && s_axil_awready) begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= {s_axil_awaddr[4:2], 2'b00};
      end
      if (s_axil_wvalid && s_axil_wready) begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axil_wdata;
        wstrb0_q <= s_axil_wstrb[0];
      end
      if (do_wr) begin
        aw_hold_q     <= 1'b0;
        w_hold_q      <= 1'b0;
        s_axil_bvalid <= 1'b1;
        s_axil_bresp  <= wr_map ? `ARQ_RESP_OKAY : `ARQ_RESP_SLVERR;
      end else if (s_axil_bready) begin
        s_axil_bvalid <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------------
  // read channel: one-cycle registered answer
  // ----------------------------------------------------------------------
  assign s_axil_arready = ~s_axil_rvalid;
  assign ar_hs          = s_axil_arvalid & s_axil_arready;
  assign res16          = ljust_q ? {q_data, 6'h00} : {6'h00, q_data};
  assign rd_map = (s_axil_araddr[4:2] <= 3'h6);
  // the byte holding eight result bits (high byte when left-justified, low byte when right) advances the pointer
  assign rd_adv = ar_hs & (ljust_q ? (s_axil_araddr[4:2] == 3'h5)
                                   : (s_axil_araddr[4:2] == 3'h4));

  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axil_rvalid <= 1'b0;
      s_axil_rdata  <= 32'h00000000;
      s_axil_rresp  <= `ARQ_RESP_OKAY;
    end else if (ar_hs) begin
      s_axil_rvalid <= 1'b1;
      s_axil_rresp  <= rd_map ? `ARQ_RESP_OKAY : `ARQ_RESP_SLVERR;
      case ({s_axil_araddr[4:2], 2'b00})
        `ARQ_OFF_CTL0:   s_axil_rdata <= {29'h0, cont_q, go_q, on_q};
        `ARQ_OFF_CTL1:   s_axil_rdata <= {27'h0, qen_q, q_empty, q_ovr, rptr};
        `ARQ_OFF_CTL2:   s_axil_rdata <= {24'h0, ljust_q, acq_q, 3'h0};
        `ARQ_OFF_CTL3:   s_axil_rdata <= {24'h0, rate_q, 1'b0, tsel_q};
        `ARQ_OFF_RES_LO: s_axil_rdata <= {24'h0, res16[7:0]};
        `ARQ_OFF_RES_HI: s_axil_rdata <= {24'h0, res16[15:8]};
        `ARQ_OFF_STAT:   s_axil_rdata <= {31'h0, irqf_q};
        default:         s_axil_rdata <= 32'h00000000;
      endcase
    end else if (s_axil_rready) begin
      s_axil_rvalid <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // configuration registers
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      on_q    <= 1'b0;
      cont_q  <= 1'b0;
      qen_q   <= 1'b0;
      ljust_q <= 1'b0;
      acq_q   <= `ARQ_RST_ACQ;
      rate_q  <= `ARQ_RST_RATE;
      tsel_q  <= `ARQ_RST_TSEL;
    end else begin
      if (w_ctl0) begin
        on_q   <= wdata_q[`ARQ_CTL0_ON];
        cont_q <= wdata_q[`ARQ_CTL0_CONT];
      end
      if (w_ctl1) begin
        qen_q <= wdata_q[`ARQ_CTL1_QEN]; // pointer bits ignored
      end
      if (w_ctl2) begin
        ljust_q <= wdata_q[`ARQ_CTL2_LJUST];
        acq_q   <= wdata_q[`ARQ_CTL2_ACQ_HI:`ARQ_CTL2_ACQ_LO];
      end
      if (w_ctl3) begin
        rate_q <= wdata_q[`ARQ_CTL3_RATE_HI:`ARQ_CTL3_RATE_LO];
        tsel_q <= wdata_q[`ARQ_CTL3_TSEL_HI:0];
      end
    end
  end

  // ----------------------------------------------------------------------
  // go bit: software, triggers, completion
  // ----------------------------------------------------------------------
  assign trig_hit  = |(trig_in & tsel_q);
  assign go_set    = (w_ctl0 & wdata_q[`ARQ_CTL0_GO]) | trig_hit;
  assign go_clr_sw = w_ctl0 & ~wdata_q[`ARQ_CTL0_GO];
  assign seq_start = state_q[2'd0] & go_q & on_q;
  assign conv_end  = state_q[2'd2] & go_q & tick & (tcnt_q == `ARQ_CONV_TADS - 4'h1);
  assign abort     = state_q[2'd2] & ~go_q;
  assign q_wr      = conv_end | abort;
  assign irq_set   = conv_end & (~cont_q | rate_hit);

  always @(posedge aclk) begin
    if (!aresetn || !on_q) begin
      go_q <= 1'b0;
    end else if (go_set) begin
      go_q <= 1'b1;                  // set wins over software and completion clears
    end else if (go_clr_sw || (conv_end && !cont_q)) begin
      go_q <= 1'b0;
    end
  end

  // interrupt flag, cleared by writing one
  always @(posedge aclk) begin
    if (!aresetn) begin
      irqf_q <= 1'b0;
    end else if (irq_set) begin
      irqf_q <= 1'b1;
    end else if (w_stat && wdata_q[`ARQ_STAT_IRQ]) begin
      irqf_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // sequencer next state
  // ----------------------------------------------------------------------
  always @* begin
    state_d = state_q;
    case (state_q)
      S_IDLE: begin
        if (seq_start) begin
          state_d = (acq_q == 4'h0) ? S_CONV : S_ACQ;
        end
      end
      S_ACQ: begin
        if (!go_q) begin
          state_d = S_WAIT;
        end else if (tick && tcnt_q == acq_q - 4'h1) begin
          state_d = S_CONV;
        end
      end
      S_CONV: begin
        if (q_wr) begin
          state_d = S_WAIT;
        end
      end
      S_WAIT: begin
        if (tick && tcnt_q == `ARQ_POST_TADS - 4'h1) begin
          if (go_q && cont_q) begin
            state_d = (acq_q == 4'h0) ? S_CONV : S_ACQ;
          end else begin
            state_d = S_IDLE;
          end
        end
      end
      default: state_d = S_IDLE;
    endcase
  end

  // ----------------------------------------------------------------------
  // sequencer state, period counter, analog controls
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn || !on_q) begin
      state_q      <= S_IDLE;
      tcnt_q       <= 4'h0;
      hold_connect <= 1'b1;
      conv_run     <= 1'b0;
    end else begin
      state_q      <= state_d;
      hold_connect <= ~state_d[2'd2];
      conv_run     <= state_d[2'd2];
      if (state_d != state_q) begin
        tcnt_q <= 4'h0;
      end else if (tick) begin
        tcnt_q <= tcnt_q + 4'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // converter period ticks and result queue
  // ----------------------------------------------------------------------
  arq_tick_div #(
    .DIV (CLKS_PER_TAD),
    .W   (16)
  ) u_tick (
    .aclk    (aclk),
    .aresetn (aresetn),
    .run     (on_q),
    .tick    (tick)
  );

  arq_result_queue #(
    .DW (10)
  ) u_queue (
    .aclk               (aclk),
    .aresetn            (aresetn),
    .enable             (qen_q),
    .seq_start          (seq_start),
    .wr                 (q_wr),
    .wr_data            (adc_result),
    .rd_adv             (rd_adv),
    .ovr_clr            (w_ctl1 & wdata_q[`ARQ_CTL1_OVR]),
    .rate               (rate_q),
    .rd_data            (q_data),
    .read_pointer       (rptr),
    .queue_empty_flag   (q_empty),
    .queue_overrun_flag (q_ovr),
    .rate_hit           (rate_hit)
  );

endmodule // arq_adc_ctrl

`default_nettype wire

// ---- logic/arq_consts.vh ----
// Constants for the converter result queue and acquisition control.
// Assumes: included by the design files by bare name; definitions only.
`ifndef ARQ_CONSTS_VH
`define ARQ_CONSTS_VH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define ARQ_ADDR_W        5
`define ARQ_OFF_CTL0      5'h00
`define ARQ_OFF_CTL1      5'h04
`define ARQ_OFF_CTL2      5'h08
`define ARQ_OFF_CTL3      5'h0c
`define ARQ_OFF_RES_LO    5'h10
`define ARQ_OFF_RES_HI    5'h14
`define ARQ_OFF_STAT      5'h18

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ARQ_CTL0_ON       0
`define ARQ_CTL0_GO       1
`define ARQ_CTL0_CONT     2
`define ARQ_CTL1_QEN      4
`define ARQ_CTL1_EMPTY    3
`define ARQ_CTL1_OVR      2
`define ARQ_CTL2_LJUST    7
`define ARQ_CTL2_ACQ_LO   3
`define ARQ_CTL2_ACQ_HI   6
`define ARQ_CTL3_RATE_LO  6
`define ARQ_CTL3_RATE_HI  7
`define ARQ_CTL3_TSEL_HI  4
`define ARQ_STAT_IRQ      0

// ----------------------------------------------------------------------
// reset values, timing and bus response codes
// ----------------------------------------------------------------------
`define ARQ_RST_ACQ       4'h0
`define ARQ_RST_RATE      2'h0
`define ARQ_RST_TSEL      5'h00
`define ARQ_CONV_TADS     4'hc
`define ARQ_POST_TADS     4'h2
`define ARQ_RESP_OKAY     2'h0
`define ARQ_RESP_SLVERR   2'h2

`endif

// ---- logic/arq_tick_div.v ----
// Converter clock period divider: one-cycle tick every DIV clocks.
// Assumes: single clock aclk, synchronous active-low reset.
`timescale 1ns/100ps
`default_nettype none

module arq_tick_div #(
  parameter DIV = 16,
  parameter W   = 8
) (
  input  wire         aclk,
  input  wire         aresetn,
  input  wire         run,
  output reg          tick
);

  reg [W-1:0] cnt_q;

  // ----------------------------------------------------------------------
  // free-running count while run is high
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn || !run) begin
      cnt_q <= {W{1'b0}};
      tick  <= 1'b0;
    end else if (cnt_q == DIV[W-1:0] - 1'b1) begin
      cnt_q <= {W{1'b0}};
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 1'b1;
      tick  <= 1'b0;
    end
  end

endmodule // arq_tick_div

`default_nettype wire

// ---- logic/arq_result_queue.v ----
// Four-slot circular result queue with unread tracking and write counting.
// Assumes: writes and reads are one-cycle pulses from the controller.
`timescale 1ns/100ps
`default_nettype none
`include "arq_consts.vh"

module arq_result_queue #(
  parameter DW = 10
) (
  input  wire          aclk,
  input  wire          aresetn,
  input  wire          enable,
  input  wire          seq_start,
  input  wire          wr,
  input  wire [DW-1:0] wr_data,
  input  wire          rd_adv,
  input  wire          ovr_clr,
  input  wire [1:0]    rate,
  output wire [DW-1:0] rd_data,
  output wire [1:0]    read_pointer,
  output wire          queue_empty_flag,
  output reg           queue_overrun_flag,
  output wire          rate_hit
);

  reg [DW-1:0] mem [0:3];
  reg [3:0]    unread_q;
  reg [1:0]    wp_q;
  reg [1:0]    rp_q;
  reg [1:0]    wcnt_q;
  wire [1:0]   wslot;
  wire [1:0]   rslot;

  // disabled queue behaves as a single slot
  assign wslot            = enable ? wp_q : 2'h0;
  assign rslot            = enable ? rp_q : 2'h0;
  assign rd_data          = mem[rslot];
  assign read_pointer     = rp_q;
  assign queue_empty_flag = ~|unread_q;
  assign rate_hit = wr & ((rate == 2'h0) | ((rate == 2'h1) & wcnt_q[0]) |
                          (rate[1] & (wcnt_q == 2'h3)));

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (wr) begin
      mem[wslot] <= wr_data;
    end
  end

  // ----------------------------------------------------------------------
  // pointers, unread bits, flags
  // ----------------------------------------------------------------------
  always @(posedge aclk) begin
    if (!aresetn) begin
      unread_q           <= 4'h0;
      wp_q               <= 2'h0;
      rp_q               <= 2'h0;
      wcnt_q             <= 2'h0;
      queue_overrun_flag <= 1'b0;
    end else begin
      if (rd_adv) begin
        unread_q[rslot] <= 1'b0;
      end
      if (wr) begin
        unread_q[wslot] <= 1'b1;  // set wins over read
        wcnt_q          <= wcnt_q + 2'h1;
        if (enable) begin
          wp_q <= wp_q + 2'h1;    // wraps 3 to 0
        end
      end
      if (seq_start) begin
        rp_q <= 2'h0;
      end else if (rd_adv && enable) begin
        rp_q <= rp_q + 2'h1;
      end
      if (wr && unread_q[wslot] && !(rd_adv && rslot == wslot)) begin
        queue_overrun_flag <= 1'b1;
      end else if (ovr_clr) begin
        queue_overrun_flag <= 1'b0;
      end
    end
  end

endmodule // arq_result_queue

`default_nettype wire

// ---- verif/arq_analog_model.sv ----
// Analog side model: hold capacitor tracking the selected input.
// Assumes: driven by hold_connect of the converter control block.
`timescale 1ns/100ps
`default_nettype none

module arq_analog_model (
  input  wire logic       aclk,
  input  wire logic       hold_connect,
  input  wire logic [9:0] vin,
  output logic      [9:0] adc_result
);
  logic [9:0] held_q;

  // capacitor follows the input while connected, keeps charge after
  always_ff @(posedge aclk) begin
    if (hold_connect) held_q <= vin;
  end

  // no conversion running: value is not valid, show the inverse
  assign adc_result = hold_connect ? ~held_q : held_q;
endmodule // arq_analog_model

`default_nettype wire

// ---- verif/arq_properties.sv ----
// Checker for the converter control block: bus answers and sequencing.
// Assumes: bound to arq_adc_ctrl; synchronous active-low reset on aclk.
`timescale 1ns/100ps
`default_nettype none
`include "arq_consts.vh"

module arq_props #(
  parameter CLKS_PER_TAD = 16
) (
  input wire logic       aclk,
  input wire logic       aresetn,
  input wire logic       s_axil_awvalid,
  input wire logic       s_axil_awready,
  input wire logic       s_axil_wvalid,
  input wire logic       s_axil_wready,
  input wire logic       s_axil_bvalid,
  input wire logic       s_axil_bready,
  input wire logic [4:0] s_axil_araddr,
  input wire logic       s_axil_arvalid,
  input wire logic       s_axil_arready,
  input wire logic [1:0] s_axil_rresp,
  input wire logic       s_axil_rvalid,
  input wire logic       s_axil_rready,
  input wire logic       hold_connect,
  input wire logic       conv_run
);
  localparam int RUN_MAX = 13 * CLKS_PER_TAD;
  logic [9:0] run_len_q;

  // ----------------------------------------
  // length of the running conversion
  // ----------------------------------------
  always_ff @(posedge aclk) begin
    if (!aresetn || !conv_run) run_len_q <= 10'h000;
    else run_len_q <= run_len_q + 10'h001;
  end

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_hold_vs_run: assert property (conv_run != hold_connect)
    else $error("hold switch and run flag disagree");
  a_conv_bound: assert property (run_len_q <= RUN_MAX)
    else $error("conversion runs too long");
  a_post_wait: assert property ($fell(conv_run) |-> !conv_run [*3])
    else $error("restart inside the wait after conversion");
  a_b_stands: assert property (s_axil_bvalid && !s_axil_bready |=> s_axil_bvalid)
    else $error("write response dropped early");
  a_r_stands: assert property (s_axil_rvalid && !s_axil_rready |=> s_axil_rvalid)
    else $error("read response dropped early");
  a_ar_refuse: assert property (s_axil_arready == !s_axil_rvalid)
    else $error("read address ready wrong");
  a_aw_refuse: assert property (s_axil_bvalid |-> !s_axil_awready && !s_axil_wready)
    else $error("write taken while response pending");
  a_wr_answer: assert property
    (s_axil_awvalid && s_axil_awready && s_axil_wvalid && s_axil_wready |-> ##2 s_axil_bvalid)
    else $error("write response late");
  a_rd_answer: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rvalid)
    else $error("read response late");
  a_rd_resp: assert property (s_axil_arvalid && s_axil_arready |=> s_axil_rresp ==
    (($past(s_axil_araddr[4:2]) == 3'h7) ? `ARQ_RESP_SLVERR : `ARQ_RESP_OKAY))
    else $error("read response code wrong");

  c_conv: cover property ($rose(conv_run));
  c_abort: cover property ($fell(conv_run) && run_len_q < 10'h010);
  c_unmapped: cover property (s_axil_arvalid && s_axil_arready && s_axil_araddr > 5'h18);
endmodule // arq_props

bind arq_adc_ctrl arq_props #(.CLKS_PER_TAD(CLKS_PER_TAD)) u_props (.aclk, .aresetn,
  .s_axil_awvalid, .s_axil_awready, .s_axil_wvalid, .s_axil_wready, .s_axil_bvalid,
  .s_axil_bready, .s_axil_araddr, .s_axil_arvalid, .s_axil_arready, .s_axil_rresp,
  .s_axil_rvalid, .s_axil_rready, .hold_connect, .conv_run);

`default_nettype wire

// ---- verif/adc_result_buffer_acq_control_tb.sv ----
// Testbench for the converter control block: queue, starts, rates, abort.
// Assumes: arq_adc_ctrl with CLKS_PER_TAD of 2, analog model on adc_result.
`timescale 1ns/100ps
`default_nettype none
`include "arq_consts.vh"

module adc_result_buffer_acq_control_tb;
  localparam int CONV_CLOCK_PERIOD = 2;
  logic        aclk = 1'b0;
  logic        aresetn = 1'b0;
  logic [4:0]  awaddr = 5'h00;
  logic [4:0]  araddr = 5'h00;
  logic [4:0]  trig = 5'h00;
  logic [31:0] wdata = 32'h0;
  logic        awvalid = 1'b0;
  logic        wvalid = 1'b0;
  logic        bready = 1'b0;
  logic        arvalid = 1'b0;
  logic        rready = 1'b0;
  logic [9:0]  vin = 10'h000;
  logic [9:0]  adc, e;
  logic [31:0] rdata, d;
  logic [1:0]  bresp, rresp, r;
  logic        awready, wready, bvalid, arready, rvalid, hold, run;
  logic [31:0] rng = 32'h6ae453a3;
  logic [9:0]  v [0:4];
  int          fail_count = 0;
  int          n_compared = 0;
  int          cyc = 0;
  int          k, a, n, t0;

  always #25 aclk = ~aclk;

  arq_adc_ctrl #(.CLKS_PER_TAD(CONV_CLOCK_PERIOD)) u_dut (
    .aclk(aclk), .aresetn(aresetn), .s_axil_awaddr(awaddr), .s_axil_awvalid(awvalid),
    .s_axil_awready(awready), .s_axil_wdata(wdata), .s_axil_wstrb(4'hf),
    .s_axil_wvalid(wvalid), .s_axil_wready(wready), .s_axil_bresp(bresp),
    .s_axil_bvalid(bvalid), .s_axil_bready(bready), .s_axil_araddr(araddr),
    .s_axil_arvalid(arvalid), .s_axil_arready(arready), .s_axil_rdata(rdata),
    .s_axil_rresp(rresp), .s_axil_rvalid(rvalid), .s_axil_rready(rready),
    .trig_in(trig), .adc_result(adc), .hold_connect(hold), .conv_run(run));

  arq_analog_model u_ana (.aclk(aclk), .hold_connect(hold), .vin(vin), .adc_result(adc));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] x;
    x = s ^ (s << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction

  // expected result byte for a justification
  function automatic logic [31:0] jb(input logic [9:0] val, input logic lj, input logic hi);
    logic [15:0] f;
    f = lj ? {val, 6'h00} : {6'h00, val};
    return {24'h0, hi ? f[15:8] : f[7:0]};
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic wr(input logic [4:0] ad, input logic [31:0] dt, input logic [1:0] er);
    logic aw_ok, w_ok;
    @(posedge aclk);
    awaddr <= ad;
    wdata <= dt;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    while (!(aw_ok && w_ok)) begin
      @(posedge aclk);
      if (!aw_ok && awready === 1'b1) begin
        aw_ok = 1'b1;
        awvalid <= 1'b0;
      end
      if (!w_ok && wready === 1'b1) begin
        w_ok = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1) @(posedge aclk);
    bready <= 1'b0;
    chk({30'h0, bresp}, {30'h0, er}, "bresp");
  endtask

  task automatic rd(input logic [4:0] ad, output logic [31:0] dt, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= ad;
    arvalid <= 1'b1;
    rready <= 1'b1;
    @(posedge aclk);
    while (arready !== 1'b1) @(posedge aclk);
    arvalid <= 1'b0;
    @(posedge aclk);
    while (rvalid !== 1'b1) @(posedge aclk);
    dt = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic rchk(input logic [4:0] ad, input logic [31:0] m, input logic [31:0] ex,
                      input string what);
    logic [31:0] dt;
    logic [1:0]  rs;
    rd(ad, dt, rs);
    chk(dt & m, ex, what);
  endtask

  // poll go/done until the block clears it
  task automatic wait_done();
    logic [31:0] dt;
    logic [1:0]  rs;
    dt = 32'h2;
    while (dt[1] !== 1'b0) rd(`ARQ_OFF_CTL0, dt, rs);
  endtask

  task automatic conv(input logic [9:0] val);
    @(posedge aclk);
    vin <= val;
    repeat (2 * CONV_CLOCK_PERIOD) @(posedge aclk);
    wr(`ARQ_OFF_CTL0, 32'h3, `ARQ_RESP_OKAY);
    wait_done();
  endtask

  task automatic pulse(input logic [4:0] p);
    @(posedge aclk);
    trig <= p;
    @(posedge aclk);
    trig <= 5'h00;
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  // watchdog on cycle count
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      $display("ERROR t=%0t watchdog expired", $time);
      give_verdict();
    end
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(`ARQ_OFF_CTL1, 32'hff, 32'h08, "ctl1 reset");
    wr(`ARQ_OFF_CTL1, 32'h03, `ARQ_RESP_OKAY);
    rchk(`ARQ_OFF_CTL1, 32'hff, 32'h08, "ptr written");
    rd(`ARQ_OFF_RES_LO, d, r);
    rchk(`ARQ_OFF_CTL1, 32'h03, 32'h0, "ptr queue off");
    wr(5'h1c, 32'h0, `ARQ_RESP_SLVERR);
    rd(5'h1c, d, r);
    chk({30'h0, r}, {30'h0, `ARQ_RESP_SLVERR}, "rresp");
    $display("test reset done");
    wr(`ARQ_OFF_CTL1, 32'h10, `ARQ_RESP_OKAY);
    wr(`ARQ_OFF_CTL0, 32'h1, `ARQ_RESP_OKAY);
    repeat (200) @(posedge aclk);
    for (k = 0; k < 5; k++) begin
      rng = xs(rng);
      v[k] = rng[9:0];
      conv(v[k]);
      rchk(`ARQ_OFF_STAT, 32'h1, 32'h1, "irq single");
      rchk(`ARQ_OFF_CTL1, 32'h0f, (k == 4) ? 32'h04 : 32'h00, "flags");
      wr(`ARQ_OFF_STAT, 32'h1, `ARQ_RESP_OKAY);
    end
    for (k = 0; k < 4; k++) begin
      e = v[(k == 0) ? 4 : k];
      rchk(`ARQ_OFF_RES_HI, 32'hff, jb(e, 1'b0, 1'b1), "right hi");
      rchk(`ARQ_OFF_RES_LO, 32'hff, jb(e, 1'b0, 1'b0), "right lo");
    end
    rchk(`ARQ_OFF_CTL1, 32'h0f, 32'h0c, "drained");
    wr(`ARQ_OFF_CTL1, 32'h14, `ARQ_RESP_OKAY);
    rchk(`ARQ_OFF_CTL1, 32'h0f, 32'h08, "ovr clear");
    wr(`ARQ_OFF_CTL2, 32'h80, `ARQ_RESP_OKAY);
    conv(v[0]);
    for (k = 0; k < 2; k++) begin
      e = (k == 0) ? v[4] : v[0];
      rchk(`ARQ_OFF_RES_LO, 32'hff, jb(e, 1'b1, 1'b0), "left lo");
      rchk(`ARQ_OFF_RES_HI, 32'hff, jb(e, 1'b1, 1'b1), "left hi");
    end
    rchk(`ARQ_OFF_CTL1, 32'h03, 32'h02, "ptr left");
    wr(`ARQ_OFF_STAT, 32'h1, `ARQ_RESP_OKAY);
    $display("test queue done");
    for (k = 0; k < 2; k++) begin
      rng = xs(rng);
      a = (k == 0) ? 0 : (rng[3:0] | 4'h1);
      wr(`ARQ_OFF_CTL2, a << 3, `ARQ_RESP_OKAY);
      wr(`ARQ_OFF_CTL0, 32'h3, `ARQ_RESP_OKAY);
      t0 = cyc;
      while (run !== 1'b1) @(posedge aclk);
      n = cyc - t0;
      chk({31'h0, n >= CONV_CLOCK_PERIOD * a - 1 && n <= CONV_CLOCK_PERIOD * a + 3}, 32'h1, "acq delay");
      wait_done();
    end
    wr(`ARQ_OFF_CTL2, 32'h0, `ARQ_RESP_OKAY);
    $display("test acquisition done");
    for (k = 0; k < 5; k++) begin
      wr(`ARQ_OFF_CTL3, 32'h1 << k, `ARQ_RESP_OKAY);
      rd(`ARQ_OFF_RES_LO, d, r);
      rng = xs(rng);
      pulse(rng[4:0] & ~(5'h01 << k));
      rchk(`ARQ_OFF_CTL0, 32'h2, 32'h0, "trigger masked");
      pulse(5'h01 << k);
      rchk(`ARQ_OFF_CTL0, 32'h2, 32'h2, "trigger go");
      wait_done();
      rchk(`ARQ_OFF_CTL1, 32'h03, 32'h0, "ptr trigger");
    end
    $display("test trigger done");
    for (k = 0; k < 4; k++) begin
      wr(`ARQ_OFF_CTL3, k << 6, `ARQ_RESP_OKAY);
      wr(`ARQ_OFF_STAT, 32'h1, `ARQ_RESP_OKAY);
      wr(`ARQ_OFF_CTL0, 32'h7, `ARQ_RESP_OKAY);
      n = 0;
      repeat (8) begin
        @(negedge run);
        rd(`ARQ_OFF_STAT, d, r);
        n += (d[0] === 1'b1) ? 1 : 0;
        wr(`ARQ_OFF_STAT, 32'h1, `ARQ_RESP_OKAY);
      end
      chk(n, 8 >> ((k == 3) ? 2 : k), "irq rate");
      wr(`ARQ_OFF_CTL0, 32'h1, `ARQ_RESP_OKAY);
      wait_done();
    end
    $display("test rate done");
    wr(`ARQ_OFF_STAT, 32'h1, `ARQ_RESP_OKAY);
    wr(`ARQ_OFF_CTL0, 32'h3, `ARQ_RESP_OKAY);
    while (run !== 1'b1) @(posedge aclk);
    repeat (6) @(posedge aclk);
    wr(`ARQ_OFF_CTL0, 32'h1, `ARQ_RESP_OKAY);
    repeat (2) @(posedge aclk);
    chk({31'h0, run}, 32'h0, "abort run");
    rchk(`ARQ_OFF_STAT, 32'h1, 32'h0, "abort irq");
    rchk(`ARQ_OFF_CTL0, 32'h2, 32'h0, "abort go");
    $display("test abort done");
    give_verdict();
  end
endmodule // adc_result_buffer_acq_control_tb

`default_nettype wire
